// file: amr_cfg.svh
// Offsets, field positions, reset values and codes of the analog
// module register bank. Included by the clock divider and the register bank.
`ifndef AMR_CFG_SVH
`define AMR_CFG_SVH

// Register indexes; byte address is four times the index
`define AMR_IDX_LOAD_CTL  8'h03
`define AMR_IDX_DAC_IN    8'h04
`define AMR_IDX_DAC_OUT   8'h06
`define AMR_IDX_ADC_RES   8'h08
`define AMR_IDX_TEMP_OFS  8'h09
`define AMR_IDX_IRQ_EN    8'h0a
`define AMR_IDX_STATUS    8'h0b
`define AMR_IDX_OSC       8'h0c

// Reset values
`define AMR_IRQ_EN_RST    16'h0001
`define AMR_OSC_RST       16'h0002

// Writable bits per register
`define AMR_DATA_MASK     16'h0fff
`define AMR_IRQ_EN_MASK   16'h0077
`define AMR_OSC_MASK      16'h0fe7

// Field positions
`define AMR_LSEL_LSB      4
`define AMR_CDIV_LSB      5
`define AMR_IE_OVR        2
`define AMR_IE_RDY        1
`define AMR_ST_IO_LVL     15
`define AMR_ST_CORE_LVL   14
`define AMR_ST_XHF        11
`define AMR_ST_HFF        6
`define AMR_ST_VIOB       5
`define AMR_ST_DVB        4
`define AMR_ST_OVR        2
`define AMR_ST_RDY        1

// Load select codes
`define AMR_LS_EXT_RISE   3'h0
`define AMR_LS_SW         3'h1
`define AMR_LS_SW_ALT     3'h3
`define AMR_LS_EXT_FALL   3'h4
`define AMR_LS_SQUARE     3'h5

// Converter clock divider: terminal counts for divide by 1..16
`define AMR_DIV_LIM1      4'h0
`define AMR_DIV_LIM2      4'h1
`define AMR_DIV_LIM4      4'h3
`define AMR_DIV_LIM8      4'h7
`define AMR_DIV_LIM16     4'hf

`endif

// file: amr_pkg.sv
// State types of the analog module register bank.
// Widths follow the 16-bit register image of the block.
package amr_pkg;

  typedef struct packed {
    logic prev;
  } amr_edge_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } amr_div_s;

  // State cleared by every reset
  typedef struct packed {
    logic [2:0]  load_sel;
    logic [11:0] dac_in;
    logic [11:0] dac_out;
    logic [11:0] dac_code;
    logic [11:0] adc_res;
    logic [15:0] temp_ofs;
    logic [15:0] irq_en;
    logic        ovr;
    logic        irq;
    logic        cpu_irq;
    logic        strobe_sel;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } amr_main_s;

  // State cleared by power-on reset only
  typedef struct packed {
    logic [15:0] osc;
    logic        rdy;
    logic        xhf;
    logic        hff;
    logic        viob;
    logic        dvb;
  } amr_por_s;

endpackage

// file: amr_edge.sv
// Rising and falling edge detector for a level already synchronous
// to pclk. Edge pulses are combinational from the input.
`timescale 1ns/1ps
module amr_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  amr_pkg::amr_edge_s st_r;
  amr_pkg::amr_edge_s st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.prev = level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rise = level & ~st_r.prev;
  assign fall = ~level & st_r.prev;

endmodule

// file: amr_clkdiv.sv
// Converter clock divider producing a one-cycle tick per divided
// period. Assumes stop_mode is a level synchronous to pclk.
`timescale 1ns/1ps
`include "amr_cfg.svh"
module amr_clkdiv (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] div_code,
  input  wire logic       stop_mode,
  output logic            adc_clk_tick
);

  amr_pkg::amr_div_s st_r;
  amr_pkg::amr_div_s st_nxt;
  logic [3:0]        lim;

  always_comb
  begin
    unique case (div_code)
      3'h0:    lim = `AMR_DIV_LIM1;
      3'h1:    lim = `AMR_DIV_LIM2;
      3'h2:    lim = `AMR_DIV_LIM4;
      3'h3:    lim = `AMR_DIV_LIM8;
      default: lim = `AMR_DIV_LIM16;
    endcase
    st_nxt = st_r;
    if (stop_mode)
    begin
      st_nxt.cnt  = 4'h0;
      st_nxt.tick = 1'b0;
    end
    else
    begin
      st_nxt.tick = (st_r.cnt >= lim);
      st_nxt.cnt  = (st_r.cnt >= lim) ? 4'h0 : st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign adc_clk_tick = st_r.tick;

endmodule

// file: amr_regs.sv
// Analog module register bank: DAC load control, ADC result and
// status flags, interrupt enables, temperature offset, clock control.
// Assumes an APB master on pclk and all pins synchronous to pclk.
// Operation
// - Select 000: copy input to output value on strobe rising edge.
// - Select 001: software write of input value also loads output.
// - Select 011 behaves exactly like 001.
// - Select 100: copy input to output value on strobe falling edge.
// - Select 101: feed input after falling, output after rising edge.
// - DAC data registers hold 12 bits; upper four read zero.
// - ADC result captured at falling edge of converter busy.
// - Temperature offset read-only, 12-bit value sign-extended to 16.
// - Interrupt enable resets to 0001h; bit 0 is spare storage.
// - Overrun enable bit 2 raises request while overrun flag set.
// - Ready enable bit 1 raises request while ready flag set.
// - Processor request needs global enable and module five mask.
// - Overrun set when busy falls while ready still set.
// - Ready set on conversion done, cleared by result read.
// - Status read clears all flags except supply level bits.
// - Overrun clears on any reset; other status on power-on only.
// - Divider codes give 1,2,4,8,16; codes above 100 give 16.
// - Divided converter clock stops in stop mode.
// - Oscillator control loads 0002h on power-on reset only.
// - Load, data, result and offset registers clear on any reset.
// - Busy high during conversion, falls when result is ready.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "amr_cfg.svh"
module amr_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_load_strobe,
  input  wire logic        converter_busy,
  input  wire logic [11:0] adc_conv_data,
  input  wire logic [11:0] temp_trim,
  input  wire logic        io_supply_level,
  input  wire logic        core_supply_level,
  input  wire logic        xhf_ready,
  input  wire logic        hf_fail_evt,
  input  wire logic        io_brownout_evt,
  input  wire logic        core_brownout_evt,
  input  wire logic        global_interrupt_enable,
  input  wire logic        module_five_mask,
  input  wire logic        stop_mode,
  output logic [11:0]      analog_output,
  output logic             strobe_pin_select,
  output logic             analog_irq_req,
  output logic             cpu_irq,
  output logic [15:0]      oscillator_control,
  output logic             adc_clk_tick
);

  amr_pkg::amr_main_s m_r;
  amr_pkg::amr_main_s m_nxt;
  amr_pkg::amr_por_s  p_r;
  amr_pkg::amr_por_s  p_nxt;

  logic        ld_rise;
  logic        ld_fall;
  logic        busy_fall;
  logic [7:0]  idx;
  logic        hit;
  logic        wr;
  logic        rd;
  logic [15:0] rval;
  logic [15:0] st_img;
  logic        sw_load;

  amr_edge u_load_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (external_load_strobe),
    .rise    (ld_rise),
    .fall    (ld_fall)
  );

  // Completion of a conversion is the falling edge of busy
  amr_edge u_busy_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (converter_busy),
    .rise    (),
    .fall    (busy_fall)
  );

  amr_clkdiv u_clkdiv (
    .pclk         (pclk),
    .presetn      (presetn),
    .div_code     (p_r.osc[`AMR_CDIV_LSB +: 3]),
    .stop_mode    (stop_mode),
    .adc_clk_tick (adc_clk_tick)
  );

  // Status image; levels are live, the rest sticky
  always_comb
  begin
    st_img                   = 16'h0000;
    st_img[`AMR_ST_IO_LVL]   = io_supply_level;
    st_img[`AMR_ST_CORE_LVL] = core_supply_level;
    st_img[`AMR_ST_XHF]      = p_r.xhf;
    st_img[`AMR_ST_HFF]      = p_r.hff;
    st_img[`AMR_ST_VIOB]     = p_r.viob;
    st_img[`AMR_ST_DVB]      = p_r.dvb;
    st_img[`AMR_ST_OVR]      = m_r.ovr;
    st_img[`AMR_ST_RDY]      = p_r.rdy;
  end

  // Decode; only word-aligned addresses are mapped
  always_comb
  begin
    idx  = paddr[9:2];
    hit  = 1'b1;
    rval = 16'h0000;
    unique case (idx)
      `AMR_IDX_LOAD_CTL:
        rval = {9'h000, m_r.load_sel, 4'h0};
      `AMR_IDX_DAC_IN:
        rval = {4'h0, m_r.dac_in};
      `AMR_IDX_DAC_OUT:
        rval = {4'h0, m_r.dac_out};
      `AMR_IDX_ADC_RES:
        rval = {4'h0, m_r.adc_res};
      `AMR_IDX_TEMP_OFS:
        rval = m_r.temp_ofs;
      `AMR_IDX_IRQ_EN:
        rval = m_r.irq_en;
      `AMR_IDX_STATUS:
        rval = st_img;
      `AMR_IDX_OSC:
        rval = p_r.osc;
      default:
        hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00)
      hit = 1'b0;
  end

  // A transfer takes effect only at the edge that ends its access phase
  assign wr = psel & penable & m_r.pready & pwrite & hit;
  assign rd = psel & penable & m_r.pready & ~pwrite & hit;

  always_comb
  begin
    m_nxt   = m_r;
    p_nxt   = p_r;
    sw_load = 1'b0;

    // One wait-free access phase: ready is raised from the setup cycle
    m_nxt.pready  = psel & ~penable;
    m_nxt.pslverr = psel & ~penable & ~hit;
    m_nxt.prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite && hit)
      m_nxt.prdata = {16'h0000, rval};

    // Register writes; read-only registers ignore writes
    if (wr)
    begin
      unique case (idx)
        `AMR_IDX_LOAD_CTL:
          m_nxt.load_sel = pwdata[`AMR_LSEL_LSB +: 3];
        `AMR_IDX_DAC_IN:
        begin
          m_nxt.dac_in = pwdata[11:0];
          sw_load      = 1'b1;
        end
        `AMR_IDX_DAC_OUT:
          m_nxt.dac_out = pwdata[11:0];
        `AMR_IDX_IRQ_EN:
          m_nxt.irq_en = pwdata[15:0] & `AMR_IRQ_EN_MASK;
        `AMR_IDX_OSC:
          p_nxt.osc = pwdata[15:0] & `AMR_OSC_MASK;
        default:
          ;
      endcase
    end

    // DAC load: strobe copies use the input value held before this cycle, software loads the written value
    unique case (m_r.load_sel)
      `AMR_LS_SW,
      `AMR_LS_SW_ALT:
        if (sw_load)
          m_nxt.dac_out = pwdata[11:0];
      `AMR_LS_EXT_RISE:
        if (ld_rise)
          m_nxt.dac_out = m_r.dac_in;
      `AMR_LS_EXT_FALL:
        if (ld_fall)
          m_nxt.dac_out = m_r.dac_in;
      default:
        ;
    endcase

    // Square wave swaps the converter source per strobe edge
    if (m_r.load_sel == `AMR_LS_SQUARE)
    begin
      if (ld_fall)
        m_nxt.dac_code = m_r.dac_in;
      else if (ld_rise)
        m_nxt.dac_code = m_r.dac_out;
    end
    else
      m_nxt.dac_code = m_nxt.dac_out;

    // Shared pin goes to the strobe in the edge-driven modes
    m_nxt.strobe_sel = (m_nxt.load_sel == `AMR_LS_EXT_RISE) ||
                       (m_nxt.load_sel == `AMR_LS_EXT_FALL) ||
                       (m_nxt.load_sel == `AMR_LS_SQUARE);

    m_nxt.temp_ofs = {{4{temp_trim[11]}}, temp_trim};

    // Read clears first, so events in the same cycle win
    if (rd && idx == `AMR_IDX_ADC_RES)
      p_nxt.rdy = 1'b0;
    if (rd && idx == `AMR_IDX_STATUS)
    begin
      m_nxt.ovr  = 1'b0;
      p_nxt.rdy  = 1'b0;
      p_nxt.xhf  = 1'b0;
      p_nxt.hff  = 1'b0;
      p_nxt.viob = 1'b0;
      p_nxt.dvb  = 1'b0;
    end

    if (busy_fall)
    begin
      m_nxt.adc_res = adc_conv_data;
      p_nxt.rdy     = 1'b1;
      if (p_r.rdy)
        m_nxt.ovr = 1'b1;
    end
    if (xhf_ready)
      p_nxt.xhf = 1'b1;
    if (hf_fail_evt)
      p_nxt.hff = 1'b1;
    if (io_brownout_evt)
      p_nxt.viob = 1'b1;
    if (core_brownout_evt)
      p_nxt.dvb = 1'b1;

    m_nxt.irq = (p_nxt.rdy & m_nxt.irq_en[`AMR_IE_RDY]) |
                (m_nxt.ovr & m_nxt.irq_en[`AMR_IE_OVR]);
    m_nxt.cpu_irq = m_nxt.irq & global_interrupt_enable &
                    module_five_mask;
  end

  // Cleared by every reset; enables come back as 0001h, strobe select as 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_r        <= '0;
      m_r.irq_en <= `AMR_IRQ_EN_RST;
      m_r.strobe_sel <= 1'b1;
    end
    else
      m_r <= m_nxt;
  end

  // Kept across every reset except power-on
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      p_r     <= '0;
      p_r.osc <= `AMR_OSC_RST;
    end
    else
      p_r <= p_nxt;
  end

  assign prdata             = m_r.prdata;
  assign pready             = m_r.pready;
  assign pslverr            = m_r.pslverr;
  assign analog_output      = m_r.dac_code;
  assign strobe_pin_select  = m_r.strobe_sel;
  assign analog_irq_req     = m_r.irq;
  assign cpu_irq            = m_r.cpu_irq;
  assign oscillator_control = p_r.osc;

endmodule

// file: amr_regs_asserts.sv
// Checker for the analog register bank, bound onto amr_regs.
// Sees only top-level ports; everything runs on pclk.
`timescale 1ns/1ps
module amr_regs_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        analog_irq_req,
  input wire logic        cpu_irq,
  input wire logic        global_interrupt_enable,
  input wire logic        module_five_mask,
  input wire logic        stop_mode,
  input wire logic [15:0] oscillator_control,
  input wire logic        adc_clk_tick
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_at(logic [7:0] idx);
    psel && !penable && !pwrite && paddr[9:2] == idx ##1 penable && pready;
  endsequence
  data_hi_a: assert property (
    (rd_at(8'h04) or rd_at(8'h06) or rd_at(8'h08)) |-> prdata[31:12] == 20'h0)
    else $error("data register upper bits not zero");
  temp_sign_a: assert property (rd_at(8'h09) |->
    prdata[15:12] == {4{prdata[11]}} && prdata[31:16] == 16'h0)
    else $error("temperature offset not sign extended");
  irq_en_rsv_a: assert property (rd_at(8'h0a) |->
    prdata[31:7] == 25'h0 && !prdata[3])
    else $error("interrupt enable reserved bits set");
  cpu_gate_a: assert property (cpu_irq |->
    $past(global_interrupt_enable) && $past(module_five_mask))
    else $error("processor request without both gates");
  cpu_src_a: assert property (cpu_irq |->
    analog_irq_req || $past(analog_irq_req))
    else $error("processor request without module request");
  stop_tick_a: assert property (
    $past(stop_mode) && stop_mode |-> !adc_clk_tick)
    else $error("converter tick in stop mode");
  // Short look only: repetitions stay small for the tools
  div16_gap_a: assert property (
    adc_clk_tick && oscillator_control[7:5] >= 3'h4 |=>
    (!adc_clk_tick || oscillator_control[7:5] < 3'h4)[*8])
    else $error("divide by 16 ticks too close");
endmodule

// file: amr_ana_model.sv
// Model of the load strobe pin and the analog converter.
// Bench sets strobe level and starts conversions of chosen length.
`timescale 1ns/1ps
module amr_ana_model (
  input  wire logic        pclk,
  input  wire logic        strobe_lvl,
  input  wire logic        conv_go,
  input  wire logic [11:0] conv_val,
  input  wire logic [3:0]  conv_len,
  output logic             external_load_strobe,
  output logic             converter_busy,
  output logic [11:0]      adc_conv_data
);
  logic [3:0]  left = 4'h0;
  logic [11:0] hold = 12'h0;
  logic        done = 1'b0;
  initial converter_busy = 1'b0;
  // Bench keeps strobe edges several cycles apart
  assign external_load_strobe = strobe_lvl;
  always @(posedge pclk)
  begin
    done <= converter_busy && left == 4'h0;
    if (conv_go && !converter_busy)
    begin
      converter_busy <= 1'b1;
      left <= conv_len;
      hold <= conv_val;
    end
    else if (converter_busy)
    begin
      left <= left - 4'h1;
      if (left == 4'h0)
        converter_busy <= 1'b0;
    end
  end
  // Result only valid around completion, inverted otherwise
  assign adc_conv_data = (done || converter_busy && left == 4'h0) ?
                         hold : ~hold;
endmodule

// file: amr_regs_tb_top.sv
// Testbench for amr_regs: APB register tests plus converter model.
// Assumes amr_ana_model and the checker are compiled before it.
`timescale 1ns/1ps
module amr_regs_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, converter_busy, external_load_strobe;
  logic strobe_lvl = 1'b0, conv_go = 1'b0, stop_mode = 1'b0;
  logic [11:0] conv_val = 12'h0, temp_trim = 12'h0, adc_conv_data;
  logic [3:0] conv_len = 4'h1;
  logic io_supply_level = 1'b1, core_supply_level = 1'b0, xhf_ready = 1'b0;
  logic hf_fail_evt = 1'b0, io_brownout_evt = 1'b0, core_brownout_evt = 1'b0;
  logic global_interrupt_enable = 1'b1, module_five_mask = 1'b1;
  logic [11:0] analog_output;
  logic [15:0] oscillator_control;
  logic strobe_pin_select, analog_irq_req, cpu_irq, adc_clk_tick;
  logic [7:0] tk;
  int num_errors = 0, n_tests = 0, cyc = 0;
  logic [7:0] ridx [6] = '{8'h03, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c};
  logic [31:0] rexp [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h2};
  amr_regs uut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_load_strobe,
    .converter_busy, .adc_conv_data, .temp_trim, .io_supply_level,
    .core_supply_level, .xhf_ready, .hf_fail_evt, .io_brownout_evt,
    .core_brownout_evt, .global_interrupt_enable, .module_five_mask,
    .stop_mode, .analog_output, .strobe_pin_select, .analog_irq_req,
    .cpu_irq, .oscillator_control, .adc_clk_tick);
  amr_ana_model u_ana (.pclk, .strobe_lvl, .conv_go, .conv_val, .conv_len,
    .external_load_strobe, .converter_busy, .adc_conv_data);
  always #20 pclk = ~pclk;
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ends at a falling edge so callers see settled outputs
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge that samples pready high
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("register %h", idx), rd, exp);
  endtask
  task automatic strb(input logic v);
    @(posedge pclk);
    strobe_lvl <= v;
    repeat (4) @(negedge pclk);
  endtask
  task automatic conv(input logic [11:0] v, input logic [3:0] len);
    @(posedge pclk);
    conv_go <= 1'b1;
    conv_val <= v;
    conv_len <= len;
    @(posedge pclk);
    conv_go <= 1'b0;
    @(negedge pclk);
    while (converter_busy)
      @(negedge pclk);
    repeat (2) @(negedge pclk);
  endtask
  task automatic rst(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= !por;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(negedge pclk);
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(negedge pclk);
    foreach (ridx[i]) rdc(ridx[i], rexp[i]);
    apb(1'b0, 8'h05, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("reset values done");
    wr(8'h03, 32'h10);
    wr(8'h04, 32'hfabc);
    rdc(8'h04, 32'h0abc);
    rdc(8'h06, 32'h0abc);
    chk("dac output", analog_output, 32'habc);
    wr(8'h03, 32'h30);
    wr(8'h04, 32'h321);
    chk("dac output", analog_output, 32'h321);
    wr(8'h03, 32'h00);
    wr(8'h04, 32'h123);
    chk("dac output", analog_output, 32'h321);
    strb(1'b1);
    chk("dac output", analog_output, 32'h123);
    wr(8'h03, 32'h40);
    wr(8'h04, 32'h456);
    strb(1'b0);
    chk("dac output", analog_output, 32'h456);
    wr(8'h04, 32'h789);
    strb(1'b1);
    chk("dac output", analog_output, 32'h456);
    wr(8'h03, 32'h50);
    strb(1'b0);
    chk("dac output", analog_output, 32'h789);
    strb(1'b1);
    chk("dac output", analog_output, 32'h456);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h03, 32'(c) << 4);
      chk("pin select", strobe_pin_select, c == 0 || c == 4 || c == 5);
    end
    wr(8'h06, 32'hffff);
    rdc(8'h06, 32'h0fff);
    $display("dac tests done");
    wr(8'h0a, 32'h7);
    rdc(8'h0a, 32'h7);
    conv(12'h5a5, 4'h0);
    chk("irq request", analog_irq_req, 32'h1);
    rdc(8'h08, 32'h05a5);
    rdc(8'h0b, 32'h8000);
    conv(12'h111, 4'h9);
    conv(12'h222, 4'h2);
    rdc(8'h08, 32'h0222);
    chk("irq request", analog_irq_req, 32'h1);
    rdc(8'h0b, 32'h8004);
    rdc(8'h0b, 32'h8000);
    chk("irq request", analog_irq_req, 32'h0);
    conv(12'h333, 4'h1);
    chk("cpu irq", cpu_irq, 32'h1);
    @(posedge pclk);
    global_interrupt_enable <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("cpu irq", cpu_irq, 32'h0);
    wr(8'h0a, 32'h1);
    chk("irq request", analog_irq_req, 32'h0);
    $display("adc tests done");
    conv(12'h444, 4'h1);
    conv(12'h555, 4'h1);
    @(posedge pclk);
    hf_fail_evt <= 1'b1;
    io_brownout_evt <= 1'b1;
    core_brownout_evt <= 1'b1;
    xhf_ready <= 1'b1;
    core_supply_level <= 1'b1;
    @(posedge pclk);
    hf_fail_evt <= 1'b0;
    io_brownout_evt <= 1'b0;
    core_brownout_evt <= 1'b0;
    xhf_ready <= 1'b0;
    wr(8'h0c, 32'hffff);
    chk("osc output", oscillator_control, 32'h0fe7);
    rst(1'b0);
    rdc(8'h0b, 32'hc872);
    rdc(8'h0b, 32'hc000);
    rdc(8'h0c, 32'h0fe7);
    rdc(8'h08, 32'h0);
    rdc(8'h06, 32'h0);
    rdc(8'h03, 32'h0);
    chk("dac output", analog_output, 32'h0);
    // Sticky flag set again so power-on reset has something to clear
    @(posedge pclk);
    hf_fail_evt <= 1'b1;
    @(posedge pclk);
    hf_fail_evt <= 1'b0;
    rst(1'b1);
    rdc(8'h0c, 32'h0002);
    rdc(8'h0b, 32'hc000);
    @(posedge pclk);
    temp_trim <= 12'h800;
    rdc(8'h09, 32'hf800);
    @(posedge pclk);
    temp_trim <= 12'h7ff;
    rdc(8'h09, 32'h07ff);
    $display("reset and offset tests done");
    for (int c = 0; c < 9; c++)
    begin
      wr(8'h0c, 32'h2 | (32'(c % 8) << 5));
      @(posedge pclk);
      stop_mode <= (c == 8);
      repeat (20) @(negedge pclk);
      tk = 8'h0;
      repeat (64) @(negedge pclk) tk = tk + {7'h0, adc_clk_tick};
      chk("tick count", tk, c == 8 ? 0 : 64 >> (c > 4 ? 4 : c));
    end
    $display("divider tests done");
    end_sim();
  end
endmodule
bind amr_regs amr_regs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .analog_irq_req, .cpu_irq,
  .global_interrupt_enable, .module_five_mask, .stop_mode,
  .oscillator_control, .adc_clk_tick);
